// File: rtl/can_filter_pkg.sv
// Purpose: shared constants and types for the acceptance filter, flag and low-power block
// Assumes: one 200 MHz clock, synchronous active-high reset
// Notes: limits, counts and the filter pattern reset values live here; the core sets its other reset values
//
// Overview of operation
// [RULE_01] single mode: one 32-bit masked compare
// [RULE_02] dual mode: two 16-bit masked compares
// [RULE_03] quad mode: four 8-bit leading-id compares
// [RULE_04] closed mode: never accept, never set full
// [RULE_05] set mask bit makes id bit don't care
// [RULE_06] accept sets full flag, lowest hit wins
// [RULE_07] transmit request per empty enabled buffer
// [RULE_08] receive irq right after end of frame
// [RULE_09] wakeup irq only with ack and enable
// [RULE_10] warning flags when counter reaches 96
// [RULE_11] passive above 127, bus-off above 255
// [RULE_12] four vectors, eleven sources, global mask
// [RULE_13] flags clear by one-write, not while condition
// [RULE_14] software clears flags without read-modify-write
// [RULE_15] error counters are never writable
// [RULE_16] config writes only accepted in soft reset
// [RULE_17] transmit pin recessive in low-power modes
// [RULE_18] mode decode from stop, ack, soft reset
// [RULE_19] low-power modes stop non-register logic
// [RULE_20] sleep waits for transmit and receive to end
// [RULE_21] sleep freezes bus-off count, copy, abort
// [RULE_22] wake on activity, request clear, soft reset
// [RULE_23] after wake wait eleven recessive bits
// [RULE_24] sleep request clear ignored until acknowledged
// [RULE_25] hit index binary, held until next accept

package can_filter_pkg;

	// ************************************************
	// filter modes and counts
	// ************************************************
	localparam logic [1:0] mode_single = 2'h0;
	localparam logic [1:0] mode_dual = 2'h1;
	localparam logic [1:0] mode_quad = 2'h2;
	localparam logic [1:0] mode_closed = 2'h3;
	localparam logic [8:0] warn_limit = 9'h060;
	localparam logic [8:0] passive_limit = 9'h07f;
	localparam logic [8:0] busoff_limit = 9'h0ff;
	localparam logic [3:0] wake_recessive_bits = 4'hb;
	localparam int fifo_depth = 32;
	localparam int fifo_width = 32;

	// ************************************************
	// reset values
	// ************************************************
	localparam logic [31:0] pattern_reset = 32'h0000_0000;
	localparam logic [31:0] dont_care_reset = 32'hffff_ffff;

	typedef enum logic [3:0] {
		st_normal = 4'h1,
		st_sleep_wait = 4'h2,
		st_sleep = 4'h4,
		st_wake_sync = 4'h8
	} sleep_state_t;

	// configuration, locked outside soft reset
	typedef struct packed {
		logic [1:0] filter_mode;
		logic [31:0] id_accept_pattern;
		logic [31:0] id_dont_care_pattern;
	} filter_cfg_t;

	// error-type flags, bit order matches the enable port
	typedef struct packed {
		logic overrun_flag;
		logic bus_off_flag;
		logic tx_passive_flag;
		logic rx_passive_flag;
		logic tx_warning_flag;
		logic rx_warning_flag;
	} err_flags_t;

	// four vector request lines
	typedef struct packed {
		logic wakeup;
		logic error;
		logic receive;
		logic transmit;
	} irq_t;

endpackage : can_filter_pkg

// File: rtl/can_filter_fifo.sv
// Purpose: frame fifo between the bus side and the foreground copy
// Assumes: single clock, synchronous reset
// Notes: depth must be a power of two
`timescale 1ns/1ps
module can_filter_fifo #(
	parameter int width = 32,
	parameter int depth = 32
) (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic [width-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready,
	output logic [width-1:0] out_data,
	output logic out_valid,
	input wire logic out_ready
);
	localparam int aw = $clog2(depth);

	// ************************************************
	// storage and pointers
	// ************************************************
	typedef struct packed {
		logic [aw:0] wr_ptr; // extra bit tells full from empty
		logic [aw:0] rd_ptr;
	} fifo_state_t;

	fifo_state_t state;
	fifo_state_t next_state;
	logic [width-1:0] mem [depth];
	logic push;
	logic pop;

	assign in_ready = (state.wr_ptr - state.rd_ptr) != (aw+1)'(depth);
	assign out_valid = state.wr_ptr != state.rd_ptr;
	assign out_data = mem[state.rd_ptr[aw-1:0]];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	// pointer update
	always_comb
	begin
		next_state = state;
		if (push)
		begin
			next_state.wr_ptr = state.wr_ptr + 1'b1;
		end
		if (pop)
		begin
			next_state.rd_ptr = state.rd_ptr + 1'b1;
		end
	end

	// register pointers; memory has no reset
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state <= '0;
		end
		else
		begin
			state <= next_state;
		end
		if (push)
		begin
			mem[state.wr_ptr[aw-1:0]] <= in_data;
		end
	end
endmodule : can_filter_fifo

// File: rtl/can_filter_core.sv
// Purpose: acceptance filter, interrupt flags, config lock and low-power control
// Assumes: bus-side events arrive as one-cycle pulses on sys_clk; bus pins are async
// Notes: a fifo holds frame ids while the foreground is busy
`timescale 1ns/1ps
module can_filter_core (
	input wire logic sys_clk,
	input wire logic srst,
	// configuration write port
	input wire logic cfg_write,
	input wire can_filter_pkg::filter_cfg_t cfg_data,
	// frame side
	input wire logic [31:0] frame_id,
	input wire logic frame_eof,
	input wire logic frame_own,
	output logic frame_ready,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic bit_tick,
	input wire logic can_rx_pin,
	input wire logic tx_bit,
	input wire logic [2:0] tx_buffer_empty_set,
	input wire logic [8:0] rx_error_count,
	input wire logic [8:0] tx_error_count,
	// software flag control
	input wire logic receive_full_clear,
	input wire logic [2:0] tx_empty_clear,
	input wire logic [5:0] err_flag_clear,
	input wire logic wakeup_clear,
	input wire logic receive_irq_enable,
	input wire logic [2:0] tx_buffer_irq_enable,
	input wire logic [5:0] err_irq_enable,
	input wire logic wakeup_irq_enable,
	input wire logic global_irq_mask,
	input wire logic sleep_request_set,
	input wire logic sleep_request_clear,
	input wire logic soft_reset_bit,
	input wire logic cpu_stop,
	// status outputs
	output logic receive_full_flag,
	output logic hit_index_high,
	output logic hit_index_low,
	output logic [2:0] tx_buffer_empty,
	output can_filter_pkg::err_flags_t err_flags,
	output logic wakeup_flag,
	output logic sleep_request,
	output logic sleep_acknowledge,
	output logic power_down,
	output logic bus_off_frozen,
	output logic can_transmit_pin,
	output can_filter_pkg::irq_t irq,
	output can_filter_pkg::filter_cfg_t cfg_view
);

	// ************************************************
	// state
	// ************************************************
	typedef struct packed {
		can_filter_pkg::filter_cfg_t cfg;
		can_filter_pkg::sleep_state_t sleep_state;
		logic [1:0] rx_sync;          // rx pin synchroniser
		logic [1:0] stop_sync;        // stop level synchroniser
		logic [3:0] recessive_count;  // wake-up resync count
		logic rx_full;
		logic [1:0] hit;
		logic [2:0] tx_empty;
		can_filter_pkg::err_flags_t err;
		logic wake;
		logic slp_req;
		logic pwr_down;
		logic frozen;
		logic tx_pin;
		can_filter_pkg::irq_t irq;
	} core_state_t;

	core_state_t state;
	core_state_t next_state;

	localparam int fifo_width_c = can_filter_pkg::fifo_width;
	logic [fifo_width_c-1:0] fifo_out;
	logic fifo_valid;
	logic fifo_pop;
	logic [3:0] hit_vec;
	logic [1:0] hit_idx;
	logic accept;
	logic low_power;
	logic sleeping;
	logic rx_level;
	logic [5:0] err_cond;
	logic offline; // off the bus: low power or wake resync

	// ************************************************
	// frame buffer
	// ************************************************
	// own frames never reach the foreground, so they are dropped here
	can_filter_fifo #(
		.width(can_filter_pkg::fifo_width),
		.depth(can_filter_pkg::fifo_depth)
	) u_fifo (
		.sys_clk(sys_clk),
		.srst(srst),
		.in_data(frame_id),
		.in_valid(frame_eof && !frame_own && !offline),
		.in_ready(frame_ready),
		.out_data(fifo_out),
		.out_valid(fifo_valid),
		.out_ready(fifo_pop)
	);

	// ************************************************
	// acceptance compare
	// ************************************************
	// one masked bit-equality vector, regrouped by single and dual; quad uses lead_ok
	logic [31:0] bit_ok;
	assign bit_ok = ~(fifo_out ^ state.cfg.id_accept_pattern)
		| state.cfg.id_dont_care_pattern; // RULE_05
	logic [31:0] lead_ok; // quad: leading id byte against each filter byte
	assign lead_ok = ~({4{fifo_out[31:24]}} ^ state.cfg.id_accept_pattern)
		| state.cfg.id_dont_care_pattern;

	always_comb
	begin
		hit_vec = 4'h0;
		unique case (state.cfg.filter_mode)
			can_filter_pkg::mode_single:
			begin
				hit_vec[0] = &bit_ok; // RULE_01
			end
			can_filter_pkg::mode_dual:
			begin
				hit_vec[0] = &bit_ok[31:16]; // RULE_02
				hit_vec[1] = &bit_ok[15:0];
			end
			can_filter_pkg::mode_quad:
			begin
				hit_vec[0] = &lead_ok[31:24]; // RULE_03
				hit_vec[1] = &lead_ok[23:16];
				hit_vec[2] = &lead_ok[15:8];
				hit_vec[3] = &lead_ok[7:0];
			end
			can_filter_pkg::mode_closed:
			begin
				hit_vec = 4'h0; // RULE_04
			end
		endcase
	end

	// lowest filter number wins
	always_comb
	begin
		hit_idx = 2'h0;
		if (hit_vec[0])
			hit_idx = 2'h0; // RULE_06
		else if (hit_vec[1])
			hit_idx = 2'h1;
		else if (hit_vec[2])
			hit_idx = 2'h2;
		else
			hit_idx = 2'h3;
	end

	assign sleeping = state.sleep_state == can_filter_pkg::st_sleep;
	assign low_power = sleeping || soft_reset_bit || state.pwr_down;
	assign offline = low_power || state.sleep_state == can_filter_pkg::st_wake_sync; // RULE_23
	// copy only while awake; a busy foreground stalls the fifo at a matching frame, non-matching ones are still popped
	assign fifo_pop = fifo_valid && !low_power && (!state.rx_full || hit_vec == 4'h0); // RULE_21
	assign accept = fifo_pop && (hit_vec != 4'h0);
	assign rx_level = state.rx_sync[1];

	// error conditions from the counters, read only
	assign err_cond[0] = rx_error_count >= can_filter_pkg::warn_limit; // RULE_10
	assign err_cond[1] = tx_error_count >= can_filter_pkg::warn_limit;
	assign err_cond[2] = rx_error_count > can_filter_pkg::passive_limit; // RULE_11
	assign err_cond[3] = tx_error_count > can_filter_pkg::passive_limit;
	assign err_cond[4] = tx_error_count > can_filter_pkg::busoff_limit;
	assign err_cond[5] = 1'b0; // overrun is event driven

	// ************************************************
	// next-state logic
	// ************************************************
	always_comb
	begin
		next_state = state;
		next_state.rx_sync = {state.rx_sync[0], can_rx_pin};
		next_state.stop_sync = {state.stop_sync[0], cpu_stop};
		next_state.pwr_down = state.stop_sync[1]; // RULE_18

		// configuration only while soft reset holds
		if (cfg_write && soft_reset_bit)
			next_state.cfg = cfg_data; // RULE_16

		// receive flag: set wins over clear; a queued match sets it again on the next accept
		if (receive_full_clear)
			next_state.rx_full = 1'b0; // RULE_13
		if (accept)
		begin
			next_state.rx_full = 1'b1; // RULE_08
			next_state.hit = hit_idx; // RULE_25
		end

		// counter-level flags; set wins over clear
		for (int i = 0; i < 6; i++)
		begin
			if (err_flag_clear[i] && !err_cond[i])
				next_state.err[i] = 1'b0; // RULE_13
			if (err_cond[i])
				next_state.err[i] = 1'b1;
		end
		if (frame_eof && !frame_own && !frame_ready && !offline)
			next_state.err.overrun_flag = 1'b1;

		// transmit empty flags; clearing queues the buffer
		for (int i = 0; i < 3; i++)
		begin
			if (tx_empty_clear[i])
				next_state.tx_empty[i] = 1'b0;
			if (tx_buffer_empty_set[i])
				next_state.tx_empty[i] = 1'b1;
		end

		if (wakeup_clear)
			next_state.wake = 1'b0;

		// sleep request bit; clear refused until acknowledged
		if (sleep_request_set)
			next_state.slp_req = 1'b1;
		else if (sleep_request_clear && sleeping)
			next_state.slp_req = 1'b0; // RULE_24

		// sleep handshake
		unique case (state.sleep_state)
			can_filter_pkg::st_normal:
			begin
				if (state.slp_req && !soft_reset_bit)
					next_state.sleep_state = can_filter_pkg::st_sleep_wait;
			end
			can_filter_pkg::st_sleep_wait:
			begin
				// queued transmits count as activity until all buffers are empty
				if (!state.slp_req || soft_reset_bit)
					next_state.sleep_state = can_filter_pkg::st_normal;
				else if (!tx_active && !rx_active && (&state.tx_empty))
					next_state.sleep_state = can_filter_pkg::st_sleep; // RULE_20
			end
			can_filter_pkg::st_sleep:
			begin
				// a dominant level on the bus is the activity
				if (!rx_level || !state.slp_req || soft_reset_bit)
				begin
					next_state.sleep_state = can_filter_pkg::st_wake_sync; // RULE_22
					next_state.recessive_count = 4'h0;
					if (!rx_level && wakeup_irq_enable)
						next_state.wake = 1'b1; // RULE_09
					if (!rx_level)
						next_state.slp_req = 1'b0;
				end
			end
			can_filter_pkg::st_wake_sync:
			begin
				if (!rx_level)
					next_state.recessive_count = 4'h0;
				else if (bit_tick)
					next_state.recessive_count = state.recessive_count + 4'h1;
				if (state.recessive_count == can_filter_pkg::wake_recessive_bits)
					next_state.sleep_state = can_filter_pkg::st_normal; // RULE_23
			end
		endcase

		// activity during power-down also wakes, acknowledge permitting
		if (state.pwr_down && sleeping && !rx_level && wakeup_irq_enable)
			next_state.wake = 1'b1; // RULE_09

		next_state.frozen = low_power; // RULE_21
		// recessive drive while any low-power mode or resync runs
		next_state.tx_pin = (offline || state.stop_sync[1] // RULE_17 RULE_19
			|| next_state.sleep_state == can_filter_pkg::st_sleep) ? 1'b1 : tx_bit;

		// vectors: local enable then global mask
		next_state.irq.transmit = global_irq_mask && |(state.tx_empty & tx_buffer_irq_enable); // RULE_07
		next_state.irq.receive = global_irq_mask && state.rx_full && receive_irq_enable; // RULE_12
		next_state.irq.error = global_irq_mask && |(state.err & err_irq_enable);
		next_state.irq.wakeup = global_irq_mask && state.wake && wakeup_irq_enable;
	end

	// ************************************************
	// registers
	// ************************************************
	always_ff @(posedge sys_clk)
	begin
		if (srst)
		begin
			state <= '0;
			state.cfg.id_accept_pattern <= can_filter_pkg::pattern_reset;
			state.cfg.id_dont_care_pattern <= can_filter_pkg::dont_care_reset;
			state.cfg.filter_mode <= can_filter_pkg::mode_single;
			state.sleep_state <= can_filter_pkg::st_normal;
			state.tx_empty <= 3'h7;
			state.rx_sync <= 2'h3;
			state.tx_pin <= 1'b1;
		end
		else
		begin
			state <= next_state;
		end
	end

	// ************************************************
	// outputs straight from state
	// ************************************************
	// the error counters are inputs only, so nothing here can change them
	assign receive_full_flag = state.rx_full; // RULE_15
	assign hit_index_high = state.hit[1];
	assign hit_index_low = state.hit[0];
	assign tx_buffer_empty = state.tx_empty;
	assign err_flags = state.err;
	assign wakeup_flag = state.wake;
	assign sleep_request = state.slp_req;
	assign sleep_acknowledge = sleeping;
	assign power_down = state.pwr_down;
	assign bus_off_frozen = state.frozen;
	assign can_transmit_pin = state.tx_pin;
	assign irq = state.irq;
	assign cfg_view = state.cfg;
endmodule : can_filter_core

// File: dv/can_filter_checker.sv
// Purpose: port-level checks for the filter, flag and low-power core
// Assumes: one clock domain, synchronous active-high reset
// Notes: outputs are registered; causes are one edge back
`timescale 1ns/1ps
module can_filter_checker (
	input wire logic sys_clk,
	input wire logic srst,
	input wire logic soft_reset_bit,
	input wire logic sleep_request_set,
	input wire logic sleep_request_clear,
	input wire logic tx_active,
	input wire logic rx_active,
	input wire logic can_rx_pin,
	input wire logic [8:0] rx_error_count,
	input wire logic [8:0] tx_error_count,
	input wire logic [2:0] tx_buffer_irq_enable,
	input wire logic receive_full_flag,
	input wire logic hit_index_high,
	input wire logic hit_index_low,
	input wire logic [2:0] tx_buffer_empty,
	input wire can_filter_pkg::err_flags_t err_flags,
	input wire logic wakeup_flag,
	input wire logic sleep_request,
	input wire logic sleep_acknowledge,
	input wire logic power_down,
	input wire logic can_transmit_pin,
	input wire can_filter_pkg::irq_t irq,
	input wire can_filter_pkg::filter_cfg_t cfg_view
);
	// ****************
	// clocking
	// ****************
	default clocking cb @(posedge sys_clk);
	endclocking
	default disable iff (srst);
	// idle request, then a quiet bus
	sequence sleep_ask;
		sleep_request_set && !tx_active && !rx_active && (&tx_buffer_empty) && !soft_reset_bit;
	endsequence
	sequence stay_quiet;
		(!tx_active && !rx_active && can_rx_pin && !sleep_request_clear && !power_down
			&& !soft_reset_bit)[*6];
	endsequence
	a_sleep_when_idle: assert property (sleep_ask ##1 stay_quiet |-> sleep_acknowledge)
		else $error("idle sleep request not acknowledged");
	a_pin_recessive: assert property ((sleep_acknowledge || power_down
		|| (soft_reset_bit && $past(soft_reset_bit))) |-> can_transmit_pin)
		else $error("transmit pin dominant in low power");
	a_closed_no_full: assert property ($rose(receive_full_flag)
		|-> $past(cfg_view.filter_mode) != can_filter_pkg::mode_closed)
		else $error("full flag set in closed mode");
	a_hit_held: assert property (!$rose(receive_full_flag)
		|-> $stable({hit_index_high, hit_index_low}))
		else $error("hit index moved");
	a_cfg_locked: assert property (!soft_reset_bit |=> $stable(cfg_view))
		else $error("configuration changed outside soft reset");
	a_sleep_clr_ignored: assert property (sleep_request && !sleep_acknowledge
		&& sleep_request_clear && !soft_reset_bit && can_rx_pin |=> sleep_request)
		else $error("early sleep request clear");
	a_warn_flag_set: assert property (rx_error_count >= can_filter_pkg::warn_limit
		&& !power_down |-> ##[1:2] err_flags.rx_warning_flag)
		else $error("receive warning flag missing");
	a_busoff_flag_set: assert property (tx_error_count > can_filter_pkg::busoff_limit
		&& !power_down |-> ##[1:2] err_flags.bus_off_flag)
		else $error("bus-off flag missing");
	a_tx_irq_cause: assert property (irq.transmit
		|-> $past(|(tx_buffer_empty & tx_buffer_irq_enable)))
		else $error("transmit request without cause");
	a_wake_flag_ack: assert property ($rose(wakeup_flag)
		|-> $past(sleep_acknowledge) || $past(sleep_acknowledge, 2))
		else $error("wakeup flag outside sleep");
endmodule : can_filter_checker
bind can_filter_core can_filter_checker can_filter_checker_inst (.sys_clk, .srst,
	.soft_reset_bit, .sleep_request_set, .sleep_request_clear, .tx_active, .rx_active,
	.can_rx_pin, .rx_error_count, .tx_error_count, .tx_buffer_irq_enable, .receive_full_flag,
	.hit_index_high, .hit_index_low, .tx_buffer_empty, .err_flags, .wakeup_flag,
	.sleep_request, .sleep_acknowledge, .power_down, .can_transmit_pin, .irq, .cfg_view);

// File: dv/can_node_model.sv
// Purpose: stands in for the other nodes on the bus
// Assumes: tasks are called 1 ns after a rising edge
// Notes: id is inverted outside end of frame
`timescale 1ns/1ps
module can_node_model (
	input wire logic sys_clk,
	output logic [31:0] frame_id,
	output logic frame_eof,
	output logic rx_active,
	output logic bit_tick,
	output logic can_rx_pin
);
	logic [1:0] div = 2'h0; // four-clock bit time
	initial
	begin
		frame_id = 32'h5a5a_a5a5;
		frame_eof = 1'h0;
		rx_active = 1'h0;
		bit_tick = 1'h0;
		can_rx_pin = 1'h1; // recessive between frames
	end
	// free-running bit tick
	always @(posedge sys_clk)
	begin
		#1;
		div = div + 2'h1;
		bit_tick = (div == 2'h0);
	end
	// dominant activity, then end of frame carrying the id
	task automatic send(input logic [31:0] id);
		rx_active = 1'h1;
		can_rx_pin = 1'h0;
		repeat (4) @(posedge sys_clk);
		#1;
		frame_id = id;
		frame_eof = 1'h1;
		rx_active = 1'h0;
		can_rx_pin = 1'h1;
		@(posedge sys_clk);
		#1;
		frame_eof = 1'h0;
		frame_id = ~id;
	endtask : send
	// receiver busy level
	task automatic busy(input logic b);
		rx_active = b;
	endtask : busy
	// dominant burst that wakes a sleeping node
	task automatic wake();
		can_rx_pin = 1'h0;
		repeat (6) @(posedge sys_clk);
		#1;
		can_rx_pin = 1'h1;
	endtask : wake
endmodule : can_node_model

// File: dv/can_filter_irq_lowpower_tb.sv
// Purpose: directed test of the filter, flag and low-power core
// Assumes: 200 MHz clock, inputs driven 1 ns after the rising edge
// Notes: frames come from the node model
`timescale 1ns/1ps
module can_filter_irq_lowpower_tb;
	// ****************
	// signals
	// ****************
	logic sys_clk = 1'h0;
	logic srst = 1'h1;
	logic cfg_write = 1'h0;
	can_filter_pkg::filter_cfg_t cfg_data = '0;
	logic frame_own = 1'h0;
	logic tx_active = 1'h0;
	logic tx_bit = 1'h1;
	logic [2:0] tx_buffer_empty_set = 3'h0;
	logic [8:0] rx_error_count = 9'h000;
	logic [8:0] tx_error_count = 9'h000;
	logic receive_full_clear = 1'h0;
	logic [2:0] tx_empty_clear = 3'h0;
	logic [5:0] err_flag_clear = 6'h00;
	logic wakeup_clear = 1'h0;
	logic receive_irq_enable = 1'h1;
	logic [2:0] tx_buffer_irq_enable = 3'h0;
	logic [5:0] err_irq_enable = 6'h3f;
	logic wakeup_irq_enable = 1'h1;
	logic global_irq_mask = 1'h1;
	logic sleep_request_set = 1'h0;
	logic sleep_request_clear = 1'h0;
	logic soft_reset_bit = 1'h0;
	logic cpu_stop = 1'h0;
	logic [31:0] frame_id;
	logic frame_eof, rx_active, bit_tick, can_rx_pin, frame_ready;
	logic receive_full_flag, hit_index_high, hit_index_low, wakeup_flag;
	logic sleep_request, sleep_acknowledge, power_down, can_transmit_pin;
	logic [2:0] tx_buffer_empty;
	can_filter_pkg::err_flags_t err_flags;
	can_filter_pkg::irq_t irq;
	can_filter_pkg::filter_cfg_t cfg_view;
	int num_errors = 0;
	int n_tests = 0;
	int cycles = 0;
	int i;
	can_node_model can_node_model_inst (.sys_clk, .frame_id, .frame_eof, .rx_active,
		.bit_tick, .can_rx_pin);
	can_filter_core can_filter_core_inst (.sys_clk, .srst, .cfg_write, .cfg_data, .frame_id,
		.frame_eof, .frame_own, .frame_ready, .tx_active, .rx_active, .bit_tick, .can_rx_pin,
		.tx_bit, .tx_buffer_empty_set, .rx_error_count, .tx_error_count, .receive_full_clear,
		.tx_empty_clear, .err_flag_clear, .wakeup_clear, .receive_irq_enable,
		.tx_buffer_irq_enable, .err_irq_enable, .wakeup_irq_enable, .global_irq_mask,
		.sleep_request_set, .sleep_request_clear, .soft_reset_bit, .cpu_stop,
		.receive_full_flag, .hit_index_high, .hit_index_low, .tx_buffer_empty, .err_flags,
		.wakeup_flag, .sleep_request, .sleep_acknowledge, .power_down, .bus_off_frozen(),
		.can_transmit_pin, .irq, .cfg_view);
	initial
	begin
		forever #2.5 sys_clk = ~sys_clk;
	end
	// ****************
	// tasks
	// ****************
	task automatic step(input int n);
		repeat (n) @(posedge sys_clk);
		#1;
	endtask : step
	task automatic chk(input string nm, input logic [65:0] e, input logic [65:0] g);
		n_tests++;
		if (g !== e)
		begin
			num_errors++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// config lands only inside soft reset
	task automatic cfgw(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k);
		soft_reset_bit = 1'h1;
		cfg_data = '{m, p, k};
		cfg_write = 1'h1;
		step(1);
		cfg_write = 1'h0;
		soft_reset_bit = 1'h0;
		step(60);
	endtask : cfgw
	task automatic clr_full();
		receive_full_clear = 1'h1;
		step(1);
		receive_full_clear = 1'h0;
		step(3);
	endtask : clr_full
	task automatic ftest(input logic [1:0] m, input logic [31:0] p, input logic [31:0] k,
		input logic [31:0] id, input logic acc, input logic [1:0] h);
		cfgw(m, p, k);
		can_node_model_inst.send(id);
		step(6);
		chk("full", acc, receive_full_flag);
		chk("rx_irq", acc, irq.receive);
		if (acc)
			chk("hit", h, {hit_index_high, hit_index_low});
		clr_full();
		chk("full_clr", 0, receive_full_flag);
	endtask : ftest
	task automatic etest(input logic [8:0] r, input logic [8:0] t, input logic [5:0] f);
		rx_error_count = r;
		tx_error_count = t;
		step(4);
		chk("err", f, err_flags);
		chk("err_irq", |f, irq.error);
		err_flag_clear = 6'h3f; // plain one-write, no read-modify-write
		step(1);
		err_flag_clear = 6'h00;
		step(2);
		chk("err_held", f, err_flags);
		rx_error_count = 9'h000;
		tx_error_count = 9'h000;
		step(1);
		err_flag_clear = 6'h3f;
		step(1);
		err_flag_clear = 6'h00;
		step(2);
		chk("err_clr", 0, err_flags);
	endtask : etest
	task automatic wait_ack(input logic v);
		for (int j = 0; j < 200 && sleep_acknowledge !== v; j++)
			step(1);
		chk("ack", v, sleep_acknowledge);
	endtask : wait_ack
	task automatic results();
		$display("checks %0d mismatches %0d", n_tests, num_errors);
		if (num_errors == 0 && n_tests > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask : results
	// hang guard
	always @(posedge sys_clk)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			num_errors++;
			results();
		end
	end
	// ****************
	// main sequence
	// ****************
	initial
	begin
		step(20);
		srst = 1'h0;
		step(1);
		chk("empty_rst", 3'h7, tx_buffer_empty);
		chk("pin_rst", 1, can_transmit_pin);
		tx_bit = 1'h0;
		cfg_data = '{can_filter_pkg::mode_quad, 32'h1, 32'h2};
		cfg_write = 1'h1;
		step(1);
		cfg_write = 1'h0;
		step(1);
		chk("cfg_lock", {can_filter_pkg::mode_single, can_filter_pkg::pattern_reset,
			can_filter_pkg::dont_care_reset}, cfg_view);
		chk("pin_normal", 0, can_transmit_pin);
		ftest(can_filter_pkg::mode_single, 32'h1234_5678, 0, 32'h1234_5678, 1, 0);
		ftest(can_filter_pkg::mode_single, 32'h1234_5678, 0, 32'h1234_5679, 0, 0);
		ftest(can_filter_pkg::mode_single, 32'h1234_5678, 32'h0000_00ff,
			32'h1234_56a5, 1, 0);
		ftest(can_filter_pkg::mode_dual, 32'haaaa_5555, 0, 32'h0000_5555, 1, 1);
		ftest(can_filter_pkg::mode_dual, 32'h1111_1111, 0, 32'h1111_1111, 1, 0);
		ftest(can_filter_pkg::mode_quad, 32'h0102_0304, 0, 32'h04ff_ffff, 1, 3);
		ftest(can_filter_pkg::mode_quad, 32'h0102_0304, 32'h0101_0101,
			32'h0300_0000, 1, 1);
		ftest(can_filter_pkg::mode_quad, 32'h0102_0304, 0, 32'h0900_0000, 0, 0);
		ftest(can_filter_pkg::mode_closed, 0, 32'hffff_ffff, 0, 0, 0);
		etest(9'h05f, 9'h000, 6'h00);
		etest(9'h060, 9'h000, 6'h01);
		etest(9'h000, 9'h060, 6'h02);
		etest(9'h07f, 9'h000, 6'h01);
		etest(9'h080, 9'h000, 6'h05);
		etest(9'h000, 9'h080, 6'h0a);
		etest(9'h000, 9'h100, 6'h1a);
		tx_buffer_irq_enable = 3'h2;
		step(3);
		chk("tx_irq", 1, irq.transmit);
		tx_empty_clear = 3'h2;
		step(1);
		tx_empty_clear = 3'h0;
		step(3);
		chk("tx_empty", 3'h5, tx_buffer_empty);
		chk("tx_irq_off", 0, irq.transmit);
		tx_buffer_empty_set = 3'h2;
		step(1);
		tx_buffer_empty_set = 3'h0;
		step(3);
		chk("tx_irq_on", 1, irq.transmit);
		// fill the fifo, then drain it
		cfgw(can_filter_pkg::mode_single, 0, 32'hffff_ffff);
		for (i = 0; i < 36; i++)
			can_node_model_inst.send(i);
		chk("fifo_full", 0, frame_ready);
		chk("overrun", 1, err_flags.overrun_flag);
		for (i = 0; i < 40; i++)
			clr_full();
		chk("fifo_empty", 1, frame_ready);
		chk("full_drained", 0, receive_full_flag);
		err_flag_clear = 6'h20;
		step(1);
		err_flag_clear = 6'h00;
		step(2);
		chk("overrun_clr", 0, err_flags.overrun_flag);
		// busy sleep, early clear, bus wake
		can_node_model_inst.busy(1);
		sleep_request_set = 1'h1;
		step(1);
		sleep_request_set = 1'h0;
		step(10);
		chk("ack_busy", 0, sleep_acknowledge);
		sleep_request_clear = 1'h1;
		step(1);
		sleep_request_clear = 1'h0;
		step(1);
		chk("req_kept", 1, sleep_request);
		can_node_model_inst.busy(0);
		wait_ack(1);
		chk("pin_sleep", 1, can_transmit_pin);
		can_node_model_inst.wake();
		step(3);
		chk("wake_flag", 1, wakeup_flag);
		chk("wake_irq", 1, irq.wakeup);
		chk("ack_woke", 0, sleep_acknowledge);
		can_node_model_inst.send(32'h0);
		step(6);
		chk("wake_frame", 0, receive_full_flag);
		step(60);
		can_node_model_inst.send(32'h0);
		step(6);
		chk("synced_frame", 1, receive_full_flag);
		clr_full();
		wakeup_clear = 1'h1;
		step(1);
		wakeup_clear = 1'h0;
		step(2);
		chk("wake_clr", 0, wakeup_flag);
		// second sleep, left by clearing the request
		sleep_request_set = 1'h1;
		step(1);
		sleep_request_set = 1'h0;
		wait_ack(1);
		step(6);
		sleep_request_clear = 1'h1;
		step(1);
		sleep_request_clear = 1'h0;
		wait_ack(0);
		// power-down and soft reset
		cpu_stop = 1'h1;
		step(4);
		chk("pdown", 1, power_down);
		chk("pin_pdown", 1, can_transmit_pin);
		cpu_stop = 1'h0;
		step(4);
		chk("pdown_off", 0, power_down);
		soft_reset_bit = 1'h1;
		step(2);
		chk("pin_soft", 1, can_transmit_pin);
		soft_reset_bit = 1'h0;
		step(2);
		global_irq_mask = 1'h0;
		step(2);
		chk("irq_mask", 0, irq);
		results();
	end
endmodule : can_filter_irq_lowpower_tb
